/* File: inc/core_pkg.sv */
// shared constants and types for the instruction timing core
package core_pkg;

    localparam int IW = 18;
    localparam int PC_W = 12;
    localparam int DW = 8;
    localparam int OP_LSB = 12;
    localparam int IDX_LSB = 8;
    localparam int IDX_W = 3;
    localparam int STACK_DEPTH = 4;
    localparam int DMEM_DEPTH = 64;
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;
    localparam logic [DW-1:0] ACC_RESET = 8'h00;
    localparam logic [DW-1:0] ADDR_PCL = 8'h02;
    localparam logic [IW-1:0] INSTR_NOP = 18'h00000;

    // one instruction cycle is four system clocks
    typedef enum logic [3:0] {
        PH0 = 4'h1,
        PH1 = 4'h2,
        PH2 = 4'h4,
        PH3 = 4'h8
    } phase_t;

    typedef enum logic [5:0] {
        OP_NOP = 6'h00, OP_MOV_AM = 6'h01, OP_MOV_MA = 6'h02,
        OP_MOV_AX = 6'h03, OP_ADD_AM = 6'h04, OP_ADD_AX = 6'h05,
        OP_ADC_AM = 6'h06, OP_SUB_AM = 6'h07, OP_SUB_AX = 6'h08,
        OP_SBC_AM = 6'h09, OP_AND_AM = 6'h0A, OP_OR_AM = 6'h0B,
        OP_XOR_AM = 6'h0C, OP_AND_AX = 6'h0D, OP_OR_AX = 6'h0E,
        OP_XOR_AX = 6'h0F, OP_INV_M = 6'h10, OP_INV_AM = 6'h11,
        OP_ADD1_M = 6'h12, OP_ADD1_AM = 6'h13, OP_SUB1_M = 6'h14,
        OP_SUB1_AM = 6'h15, OP_ROTR_M = 6'h16, OP_ROTR_AM = 6'h17,
        OP_ROTL_M = 6'h18, OP_ROTL_AM = 6'h19, OP_ROTRC_M = 6'h1A,
        OP_ROTRC_AM = 6'h1B, OP_ROTLC_M = 6'h1C, OP_ROTLC_AM = 6'h1D,
        OP_BIT_SET = 6'h1E, OP_BIT_CLR = 6'h1F, OP_BRANCH = 6'h20,
        OP_CALL = 6'h21, OP_SUB_EXIT = 6'h22, OP_INT_EXIT = 6'h23,
        OP_SKIP_Z = 6'h24, OP_SKIP_BZ = 6'h25, OP_SKIP_BNZ = 6'h26,
        OP_TBL_RD = 6'h27, OP_HALT = 6'h28, OP_WDT_CLR = 6'h29
    } op_t;

    typedef enum logic [3:0] {
        FN_PASSB = 4'h0, FN_ADD = 4'h1, FN_ADC = 4'h2, FN_SUB = 4'h3,
        FN_SBC = 4'h4, FN_AND = 4'h5, FN_OR = 4'h6, FN_XOR = 4'h7,
        FN_INV = 4'h8, FN_ADD1 = 4'h9, FN_SUB1 = 4'hA, FN_ROTR = 4'hB,
        FN_ROTL = 4'hC, FN_ROTRC = 4'hD, FN_ROTLC = 4'hE
    } alu_fn_t;

endpackage

/* File: logic/phase_seq.sv */
// four-phase instruction cycle sequencer
`timescale 1ns/1ps
module phase_seq (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // phase
    output core_pkg::phase_t o_phase,
    output logic o_cycle_end
);
    import core_pkg::*;

    phase_t ph_ff;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ph_ff <= PH0;
        end else begin
            unique case (ph_ff)
                PH0: ph_ff <= PH1;
                PH1: ph_ff <= PH2;
                PH2: ph_ff <= PH3;
                PH3: ph_ff <= PH0;
                default: ph_ff <= PH0;
            endcase
        end
    end

    assign o_phase = ph_ff;
    assign o_cycle_end = (ph_ff == PH3);
endmodule // phase_seq

/* File: logic/alu8.sv */
// eight-bit arithmetic and logic unit
`timescale 1ns/1ps
module alu8 (
    // operation
    input wire core_pkg::alu_fn_t i_fn,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_cin,
    // result
    output logic [7:0] o_res,
    output logic o_c,
    output logic o_ac,
    output logic o_ov,
    output logic o_z
);
    import core_pkg::*;

    logic [8:0] wide;
    logic [4:0] nib;
    logic cy;

    always_comb begin
        wide = 9'h000;
        nib = 5'h00;
        cy = (i_fn == FN_ADC || i_fn == FN_SBC) ? i_cin : 1'b0;
        o_res = i_b;
        o_c = i_cin;
        o_ac = 1'b0;
        o_ov = 1'b0;
        unique case (i_fn)
            FN_ADD, FN_ADC: begin
                wide = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cy};
                nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cy};
                o_res = wide[7:0];
                o_c = wide[8];
                o_ac = nib[4];
                o_ov = (i_a[7] == i_b[7]) && (wide[7] != i_a[7]);
            end
            FN_SUB, FN_SBC: begin
                // carry flag holds the borrow
                wide = {1'b0, i_a} - {1'b0, i_b} - {8'h00, cy};
                nib = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, cy};
                o_res = wide[7:0];
                o_c = wide[8];
                o_ac = nib[4];
                o_ov = (i_a[7] != i_b[7]) && (wide[7] != i_a[7]);
            end
            FN_AND: o_res = i_a & i_b;
            FN_OR: o_res = i_a | i_b;
            FN_XOR: o_res = i_a ^ i_b;
            FN_INV: o_res = ~i_b;
            FN_ADD1: o_res = i_b + 8'h01;
            FN_SUB1: o_res = i_b - 8'h01;
            FN_ROTR: o_res = {i_b[0], i_b[7:1]};
            FN_ROTL: o_res = {i_b[6:0], i_b[7]};
            FN_ROTRC: begin
                o_res = {i_cin, i_b[7:1]};
                o_c = i_b[0];
            end
            FN_ROTLC: begin
                o_res = {i_b[6:0], i_cin};
                o_c = i_b[7];
            end
            FN_PASSB: o_res = i_b;
            default: o_res = i_b;
        endcase
        o_z = (o_res == 8'h00);
    end
endmodule // alu8

/* File: logic/instr_timing_core.sv */
// instruction sequencing and execution core
`timescale 1ns/1ps

// Notes on behaviour
// - every instruction cycle is four system clocks
// - most instructions take one cycle; branch, call, table read two
// - subroutine and interrupt exits take one extra cycle
// - a write to the program counter low byte adds one cycle
// - skip costs one cycle, one more when the skip is taken
// - moves: memory to accumulator, accumulator to memory, immediate
// - addition reports carry above 255, subtraction reports borrow
// - add-one and subtract-one change the operand by exactly one
// - logical operations set zero flag when the result is zero
// - rotates shift one bit; carry variants move the lost bit to carry
// - data operations pass through the accumulator, except memory-target invert, add-one, subtract-one, rotate and bit set/clear
// - call saves next address; exit resumes there
// - branch loads target, saves no return address
// - skip tests a byte or bit and bypasses the next instruction
// - bit set and clear change only the addressed bit
// - program memory can be read as a constant table
// - halt enters power-down; a dedicated op services the watchdog
// - add-with-carry uses carry in, updates zero, carry, aux, overflow
module instr_timing_core #(
    parameter int STACK_DEPTH = core_pkg::STACK_DEPTH,
    parameter int DMEM_DEPTH = core_pkg::DMEM_DEPTH
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // program memory fetch
    output logic [core_pkg::PC_W-1:0] o_fetch_addr,
    input wire logic [core_pkg::IW-1:0] i_fetch_instr,
    // power and watchdog
    input wire logic i_wake,
    output logic o_powered_down,
    output logic o_wdt_clear,
    // status
    output core_pkg::phase_t o_phase,
    output logic o_cycle_end,
    output logic o_instr_done,
    output logic [core_pkg::PC_W-1:0] o_pc,
    output logic [core_pkg::DW-1:0] o_acc,
    output logic o_flag_z,
    output logic o_flag_c,
    output logic o_flag_ac,
    output logic o_flag_ov
);
    import core_pkg::*;

    localparam int AW = $clog2(DMEM_DEPTH);
    localparam int SPW = $clog2(STACK_DEPTH);

    function automatic logic is_pcl(input logic [DW-1:0] a);
        return a == ADDR_PCL;
    endfunction

    function automatic logic [AW-1:0] dm_idx(input logic [DW-1:0] a);
        return a[AW-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    phase_t ph;
    logic cyc_end;
    logic [IW-1:0] ir_ff;
    logic [PC_W-1:0] pc_ff, fa_ff;
    logic bubble_ff, tbl_ff, halt_ff, wdt_ff, done_ff;
    logic [DW-1:0] tm_ff, acc_ff;
    logic z_ff, c_ff, ac_ff, ov_ff;
    logic [DW-1:0] dmem_ff [DMEM_DEPTH];
    logic [PC_W-1:0] stack_ff [STACK_DEPTH];
    logic [SPW-1:0] sp_ff;

    phase_seq u_phase (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .o_phase(ph),
        .o_cycle_end(cyc_end)
    );

    ////////////////////////////////////////////////////////////////////////
    op_t op;
    logic [DW-1:0] m, rd, mask, wr_val, alu_b, alu_res;
    logic [IDX_W-1:0] bidx;
    logic [PC_W-1:0] tgt, new_pc, tbl_addr;
    alu_fn_t fn;
    logic alu_c, alu_ac, alu_ov, alu_z;
    logic wr_acc, wr_mem, upd_z, upd_c, upd_all, bit_op;
    logic skip, jump, call, ret, tbl, halt, wdt, pcl_wr, extra, fire;

    assign op = op_t'(ir_ff[IW-1:OP_LSB]);
    assign m = ir_ff[DW-1:0];
    assign bidx = ir_ff[IDX_LSB+IDX_W-1:IDX_LSB];
    assign tgt = ir_ff[PC_W-1:0];
    assign mask = 8'h01 << bidx;
    assign rd = is_pcl(m) ? 8'(pc_ff - 12'h001) : dmem_ff[dm_idx(m)];
    assign tbl_addr = {pc_ff[PC_W-1:DW], acc_ff};
    assign fire = cyc_end && !bubble_ff && !halt_ff;

    alu8 u_alu (
        .i_fn(fn),
        .i_a(acc_ff),
        .i_b(alu_b),
        .i_cin(c_ff),
        .o_res(alu_res),
        .o_c(alu_c),
        .o_ac(alu_ac),
        .o_ov(alu_ov),
        .o_z(alu_z)
    );

    // decode: accumulator is the operand path for data ops except memory-target invert, add-one, subtract-one, rotate and bit ops
    always_comb begin
        fn = FN_PASSB;
        alu_b = rd;
        {wr_acc, wr_mem, upd_z, upd_c, upd_all, bit_op} = 6'h00;
        {skip, jump, call, ret, tbl, halt, wdt} = 7'h00;
        unique case (op)
            OP_MOV_AM: wr_acc = 1'b1;
            OP_MOV_MA: begin
                alu_b = acc_ff;
                wr_mem = 1'b1;
            end
            OP_MOV_AX: begin
                alu_b = m;
                wr_acc = 1'b1;
            end
            OP_ADD_AM, OP_ADC_AM, OP_SUB_AM, OP_SBC_AM,
            OP_ADD_AX, OP_SUB_AX: begin
                fn = (op == OP_ADD_AM || op == OP_ADD_AX) ? FN_ADD :
                     (op == OP_ADC_AM) ? FN_ADC :
                     (op == OP_SBC_AM) ? FN_SBC : FN_SUB;
                if (op == OP_ADD_AX || op == OP_SUB_AX)
                    alu_b = m;
                wr_acc = 1'b1;
                upd_all = 1'b1;
            end
            OP_AND_AM, OP_OR_AM, OP_XOR_AM,
            OP_AND_AX, OP_OR_AX, OP_XOR_AX: begin
                fn = (op == OP_AND_AM || op == OP_AND_AX) ? FN_AND :
                     (op == OP_OR_AM || op == OP_OR_AX) ? FN_OR : FN_XOR;
                if (op == OP_AND_AX || op == OP_OR_AX || op == OP_XOR_AX)
                    alu_b = m;
                wr_acc = 1'b1;
                upd_z = 1'b1;
            end
            OP_INV_M, OP_INV_AM, OP_ADD1_M, OP_ADD1_AM,
            OP_SUB1_M, OP_SUB1_AM: begin
                fn = (op == OP_INV_M || op == OP_INV_AM) ? FN_INV :
                     (op == OP_ADD1_M || op == OP_ADD1_AM) ? FN_ADD1 :
                     FN_SUB1;
                wr_acc = op[0];
                wr_mem = !op[0];
                upd_z = 1'b1;
            end
            OP_ROTR_M, OP_ROTR_AM, OP_ROTL_M, OP_ROTL_AM,
            OP_ROTRC_M, OP_ROTRC_AM, OP_ROTLC_M, OP_ROTLC_AM: begin
                fn = (op == OP_ROTR_M || op == OP_ROTR_AM) ? FN_ROTR :
                     (op == OP_ROTL_M || op == OP_ROTL_AM) ? FN_ROTL :
                     (op == OP_ROTRC_M || op == OP_ROTRC_AM) ? FN_ROTRC :
                     FN_ROTLC;
                wr_acc = op[0];
                wr_mem = !op[0];
                upd_c = (fn == FN_ROTRC || fn == FN_ROTLC);
            end
            OP_BIT_SET, OP_BIT_CLR: begin
                wr_mem = 1'b1;
                bit_op = 1'b1;
            end
            OP_BRANCH: jump = 1'b1;
            OP_CALL: call = 1'b1;
            OP_SUB_EXIT, OP_INT_EXIT: ret = 1'b1;
            OP_SKIP_Z: skip = (rd == 8'h00);
            OP_SKIP_BZ: skip = !rd[bidx];
            OP_SKIP_BNZ: skip = rd[bidx];
            OP_TBL_RD: tbl = 1'b1;
            OP_HALT: halt = 1'b1;
            OP_WDT_CLR: wdt = 1'b1;
            default: fn = FN_PASSB;
        endcase
    end

    assign wr_val = !bit_op ? alu_res :
                    (op == OP_BIT_SET) ? (rd | mask) : (rd & ~mask);
    assign pcl_wr = wr_mem && is_pcl(m);
    assign extra = jump | call | ret | skip | tbl | pcl_wr;

    always_comb begin
        new_pc = pc_ff;
        if (jump || call)
            new_pc = tgt;
        else if (ret)
            new_pc = stack_ff[SPW'(sp_ff - 1'b1)];
        else if (skip)
            new_pc = pc_ff + 12'h001;
        else if (pcl_wr)
            new_pc = {pc_ff[PC_W-1:DW], wr_val};
    end

    ////////////////////////////////////////////////////////////////////////
    // fetch and sequencing
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pc_ff <= PC_RESET;
            fa_ff <= PC_RESET;
            ir_ff <= INSTR_NOP;
            bubble_ff <= 1'b1;
            tbl_ff <= 1'b0;
            tm_ff <= 8'h00;
        end else if (ph == PH1 && bubble_ff && tbl_ff) begin
            fa_ff <= pc_ff;
        end else if (cyc_end && !halt_ff) begin
            if (bubble_ff || !extra) begin
                ir_ff <= i_fetch_instr;
                pc_ff <= pc_ff + 12'h001;
                fa_ff <= pc_ff + 12'h001;
                bubble_ff <= 1'b0;
                tbl_ff <= 1'b0;
            end else begin
                ir_ff <= INSTR_NOP;
                pc_ff <= new_pc;
                fa_ff <= tbl ? tbl_addr : new_pc;
                bubble_ff <= 1'b1;
                tbl_ff <= tbl;
                tm_ff <= m;
            end
        end
    end

    // data memory
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < DMEM_DEPTH; i++)
                dmem_ff[i] <= 8'h00;
        end else if (ph == PH1 && bubble_ff && tbl_ff) begin
            dmem_ff[dm_idx(tm_ff)] <= i_fetch_instr[DW-1:0];
        end else if (fire && wr_mem && !is_pcl(m)) begin
            dmem_ff[dm_idx(m)] <= wr_val;
        end
    end

    // accumulator and flags
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_ff <= ACC_RESET;
            {z_ff, c_ff, ac_ff, ov_ff} <= 4'h0;
        end else if (fire) begin
            if (wr_acc)
                acc_ff <= alu_res;
            if (upd_z || upd_all)
                z_ff <= alu_z;
            if (upd_c || upd_all)
                c_ff <= alu_c;
            if (upd_all) begin
                ac_ff <= alu_ac;
                ov_ff <= alu_ov;
            end
        end
    end

    // return stack
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sp_ff <= '0;
            for (int i = 0; i < STACK_DEPTH; i++)
                stack_ff[i] <= PC_RESET;
        end else if (fire && call) begin
            stack_ff[sp_ff] <= pc_ff;
            sp_ff <= SPW'(sp_ff + 1'b1);
        end else if (fire && ret) begin
            sp_ff <= SPW'(sp_ff - 1'b1);
        end
    end

    // power-down and watchdog service
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            halt_ff <= 1'b0;
            wdt_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            if (fire && halt)
                halt_ff <= 1'b1;
            else if (i_wake)
                halt_ff <= 1'b0;
            wdt_ff <= fire && wdt;
            done_ff <= fire;
        end
    end

    assign o_fetch_addr = fa_ff;
    assign o_pc = pc_ff;
    assign o_acc = acc_ff;
    assign {o_flag_z, o_flag_c, o_flag_ac, o_flag_ov} =
        {z_ff, c_ff, ac_ff, ov_ff};
    assign o_powered_down = halt_ff;
    assign o_wdt_clear = wdt_ff;
    assign o_instr_done = done_ff;
    assign o_phase = ph;
    assign o_cycle_end = cyc_end;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_exec_extra;
        fire && extra;
    endsequence
    sequence s_call;
        fire && op == OP_CALL;
    endsequence

    a_cycle_four_clk: assert property (
        cyc_end |=> !cyc_end [*3] ##1 cyc_end)
        else $error("instruction cycle is not four clocks");
    a_extra_flushes: assert property (
        s_exec_extra |=> bubble_ff && ir_ff == INSTR_NOP [*4])
        else $error("extra cycle did not discard prefetch");
    a_single_cycle: assert property (
        fire && !extra |=> !bubble_ff)
        else $error("single-cycle op inserted a bubble");
    a_branch_target: assert property (
        fire && op == OP_BRANCH |=> pc_ff == $past(tgt)
            && sp_ff == $past(sp_ff))
        else $error("branch target or stack wrong");
    a_call_saves_next: assert property (
        s_call |=> stack_ff[SPW'(sp_ff - 1'b1)] == $past(pc_ff))
        else $error("call did not save next address");
    a_skip_taken: assert property (
        fire && skip |=> pc_ff == $past(pc_ff) + 12'h001 && bubble_ff)
        else $error("skip did not bypass next instruction");
    a_add_carry: assert property (
        fire && op inside {OP_ADD_AM, OP_ADD_AX} |=>
            c_ff == ($past(acc_ff) + $past(alu_b) > 9'h0FF))
        else $error("addition carry wrong");
    a_add_one_exact: assert property (
        fire && op == OP_ADD1_AM |=> acc_ff == 8'($past(rd) + 8'h01))
        else $error("add-one result wrong");
    a_logic_zero: assert property (
        fire && op inside {OP_AND_AM, OP_OR_AM, OP_XOR_AM, OP_AND_AX,
            OP_OR_AX, OP_XOR_AX} |=> z_ff == (acc_ff == 8'h00))
        else $error("zero flag wrong after logic op");
    a_bit_set_only: assert property (
        fire && op == OP_BIT_SET && !is_pcl(m) |=>
            dmem_ff[$past(dm_idx(m))] == ($past(rd) | $past(mask)))
        else $error("bit set touched other bits");
    a_halt_enters: assert property (
        fire && op == OP_HALT && !i_wake |=> o_powered_down)
        else $error("halt did not power down");
endmodule // instr_timing_core

/* File: testbench/instr_timing_core_bench.sv */
// self-checking bench for the instruction timing core
`timescale 1ns/1ps
module instr_timing_core_bench;
    import core_pkg::*;
    typedef struct {logic [7:0] acc; logic z; logic c; int gap;} note_t;
    logic i_clk;
    logic i_rst_n;
    logic i_wake;
    logic [IW-1:0] prog [0:4095];
    logic [PC_W-1:0] o_fetch_addr;
    logic [PC_W-1:0] o_pc;
    logic o_powered_down, o_wdt_clear, o_cycle_end, o_instr_done;
    logic o_flag_z, o_flag_c, o_flag_ac, o_flag_ov;
    phase_t o_phase;
    logic [DW-1:0] o_acc, acc_m, r1, r2, r3;
    logic z_m, c_m, ac_m, ov_m;
    int err_count = 0;
    int num_checks = 0;
    int pa, prev, wdt_n, gap;
    note_t q[$];

    instr_timing_core uut (
        .i_clk(i_clk), .i_rst_n(i_rst_n),
        .o_fetch_addr(o_fetch_addr), .i_fetch_instr(prog[o_fetch_addr]),
        .i_wake(i_wake), .o_powered_down(o_powered_down),
        .o_wdt_clear(o_wdt_clear), .o_phase(o_phase),
        .o_cycle_end(o_cycle_end), .o_instr_done(o_instr_done),
        .o_pc(o_pc), .o_acc(o_acc), .o_flag_z(o_flag_z),
        .o_flag_c(o_flag_c), .o_flag_ac(o_flag_ac), .o_flag_ov(o_flag_ov)
    );

    ////////////////////////////////////////
    task automatic cmp_word(input logic [11:0] got, exp, input string s);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, exp, input string s);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s got %b exp %b", $time, s, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // place one word and note what it must leave behind
    task automatic put(input op_t op, input logic [11:0] f, input int cyc);
        prog[pa] = {op, f};
        pa++;
        q.push_back('{acc_m, z_m, c_m, 4 * prev});
        prev = cyc;
    endtask

    // word that must never execute
    task automatic dead();
        prog[pa] = {OP_MOV_AX, 12'h055};
        pa++;
    endtask

    task automatic mov(input logic [7:0] v);
        acc_m = v;
        put(OP_MOV_AX, {4'h0, v}, 1);
    endtask

    task automatic lz();
        z_m = (acc_m == 8'h00);
    endtask

    task automatic addc(input logic [7:0] b, input logic ci, input logic sb);
        logic [8:0] s;
        logic [4:0] h;
        if (sb) s = {1'b0, acc_m} - {1'b0, b} - {8'h00, ci};
        else s = {1'b0, acc_m} + {1'b0, b} + {8'h00, ci};
        if (sb) h = {1'b0, acc_m[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
        else h = {1'b0, acc_m[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        ac_m = h[4];
        ov_m = ((acc_m[7] ^ b[7]) == sb) && (s[7] != acc_m[7]);
        {c_m, acc_m} = s;
        lz();
    endtask

    task automatic wait_idle(input logic pd);
        for (int i = 0; i < 2000; i++) begin
            if (q.size() == 0 && (!pd || o_powered_down === 1'b1)) break;
            @(negedge i_clk);
        end
        if (q.size() != 0 || (pd && o_powered_down !== 1'b1)) begin
            err_count++;
            $display("ERROR %0t idle wait expired", $time);
        end
    endtask

    ////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    initial begin
        repeat (4000) @(posedge i_clk);
        err_count++;
        $display("ERROR %0t watchdog expired", $time);
        end_of_test();
    end

    // watches outputs and retires notes
    initial begin
        note_t n;
        phase_t ph;
        logic pd;
        ph = PH0;
        pd = 1'b0;
        gap = 0;
        wdt_n = 0;
        forever begin
            @(posedge i_clk);
            #1;
            gap++;
            if (o_wdt_clear === 1'b1) wdt_n++;
            if (i_rst_n && !pd && o_powered_down === 1'b0) begin
                cmp_word(12'(o_phase), 12'({ph[2:0], ph[3]}), "phase");
                cmp_bit(o_cycle_end, o_phase === PH3, "cycle end");
            end
            if (o_instr_done === 1'b1) begin
                if (q.size() == 0) begin
                    err_count++;
                    $display("ERROR %0t unexpected retire", $time);
                end else begin
                    n = q.pop_front();
                    cmp_word(12'(o_acc), 12'(n.acc), "acc");
                    cmp_bit(o_flag_z, n.z, "zero");
                    cmp_bit(o_flag_c, n.c, "carry");
                    if (n.gap > 0)
                        cmp_word(12'(gap), 12'(n.gap), "clocks");
                end
                gap = 0;
            end
            ph = o_phase;
            pd = o_powered_down;
        end
    end

    ////////////////////////////////////////
    initial begin
        i_rst_n = 1'b0;
        i_wake = 1'b0;
        for (int i = 0; i < 4096; i++) prog[i] = INSTR_NOP;
        pa = 0;
        prev = 0;
        acc_m = 8'h00;
        z_m = 1'b0;
        c_m = 1'b0;
        r1 = 8'($urandom(32'hAD97)) | 8'h01;
        r2 = 8'($urandom);
        r3 = 8'($urandom);
        mov(r1);
        put(OP_MOV_MA, 12'h010, 1);
        mov(8'h00);
        acc_m = r1;
        put(OP_MOV_AM, 12'h010, 1);
        mov(8'hF0);
        addc(8'h20, 1'b0, 1'b0);
        put(OP_ADD_AX, 12'h020, 1);
        addc(r1, c_m, 1'b0);
        put(OP_ADC_AM, 12'h010, 1);
        mov(8'h30);
        addc(8'h40, 1'b0, 1'b1);
        put(OP_SUB_AX, 12'h040, 1);
        addc(r1, c_m, 1'b1);
        put(OP_SBC_AM, 12'h010, 1);
        mov(8'hFF);
        put(OP_MOV_MA, 12'h011, 1);
        z_m = 1'b1;
        put(OP_ADD1_M, 12'h011, 1);
        acc_m = 8'h00;
        put(OP_MOV_AM, 12'h011, 1);
        acc_m = r1 + 8'h01;
        lz();
        put(OP_ADD1_AM, 12'h010, 1);
        acc_m = r1 - 8'h01;
        lz();
        put(OP_SUB1_AM, 12'h010, 1);
        acc_m = 8'h00;
        lz();
        put(OP_AND_AX, 12'h000, 1);
        acc_m = r2;
        lz();
        put(OP_OR_AX, {4'h0, r2}, 1);
        acc_m = 8'h00;
        lz();
        put(OP_XOR_AX, {4'h0, r2}, 1);
        acc_m = ~r1;
        lz();
        put(OP_INV_AM, 12'h010, 1);
        mov(8'h81);
        put(OP_MOV_MA, 12'h012, 1);
        acc_m = 8'hC0;
        put(OP_ROTR_AM, 12'h012, 1);
        acc_m = 8'h03;
        put(OP_ROTL_AM, 12'h012, 1);
        acc_m = {c_m, 7'h40};
        c_m = 1'b1;
        put(OP_ROTRC_AM, 12'h012, 1);
        acc_m = {7'h01, c_m};
        put(OP_ROTLC_AM, 12'h012, 1);
        put(OP_BIT_SET, 12'h312, 1);
        put(OP_BIT_CLR, 12'h012, 1);
        acc_m = 8'h88;
        put(OP_MOV_AM, 12'h012, 1);
        put(OP_SKIP_BZ, 12'h012, 2);
        dead();
        mov(8'h11);
        put(OP_SKIP_BNZ, 12'h012, 1);
        mov(8'h22);
        put(OP_SKIP_Z, 12'h011, 2);
        dead();
        put(OP_SKIP_Z, 12'h012, 1);
        mov(8'h33);
        put(OP_BRANCH, 12'h100, 2);
        dead();
        pa = 12'h100;
        put(OP_CALL, 12'h200, 2);
        pa = 12'h200;
        mov(8'h77);
        put(OP_BRANCH, 12'h220, 2);
        dead();
        pa = 12'h220;
        put(OP_SUB_EXIT, 12'h000, 2);
        dead();
        pa = 12'h101;
        mov(8'h66);
        put(OP_CALL, 12'h230, 2);
        pa = 12'h230;
        put(OP_INT_EXIT, 12'h000, 2);
        dead();
        pa = 12'h103;
        mov(8'h40);
        put(OP_MOV_MA, 12'h002, 2);
        dead();
        pa = 12'h140;
        mov(8'hF0);
        prog[12'h1F0] = {6'h3F, 4'hA, r3};
        put(OP_TBL_RD, 12'h013, 2);
        acc_m = r3;
        put(OP_MOV_AM, 12'h013, 1);
        put(OP_WDT_CLR, 12'h000, 1);
        put(OP_HALT, 12'h000, 1);
        prog[pa] = {OP_MOV_AX, 12'h05A};
        repeat (16) @(posedge i_clk);
        @(negedge i_clk);
        i_rst_n = 1'b1;
        wait_idle(1'b1);
        cmp_word(12'(wdt_n), 12'h001, "wdt pulses");
        repeat (20) @(negedge i_clk);
        cmp_bit(o_powered_down, 1'b1, "halted");
        cmp_word(o_pc, 12'(pa + 1), "halt pc");
        cmp_bit(o_flag_ac, ac_m, "aux carry");
        cmp_bit(o_flag_ov, ov_m, "overflow");
        i_wake = 1'b1;
        @(negedge i_clk);
        i_wake = 1'b0;
        cmp_bit(o_powered_down, 1'b0, "woken");
        repeat (2) @(negedge i_clk);
        // reset lands inside the woken instruction
        i_rst_n = 1'b0;
        @(negedge i_clk);
        cmp_word(12'(o_phase), 12'(PH0), "reset phase");
        cmp_word(o_fetch_addr, PC_RESET, "reset fetch");
        cmp_word(12'(o_acc), 12'(ACC_RESET), "reset acc");
        q.push_back('{r1, 1'b0, 1'b0, 0});
        @(negedge i_clk);
        i_rst_n = 1'b1;
        wait_idle(1'b0);
        end_of_test();
    end
endmodule // instr_timing_core_bench
